//--- irbf_fifo.sv
// Purpose: Small synchronous FIFO with registered output stage
// Assumes: Single clock, synchronous active-high reset
// Notes:   inReady drops when full so the writer must hold or refuse the byte
`timescale 1ns/1ps
module irbf_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [CW-1:0]               count;
        logic                        outValid;
        logic [WIDTH-1:0]            outData;
    } irbf_fifo_s;

    irbf_fifo_s q;
    irbf_fifo_s d;

    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Output stage counts toward depth, so exactly DEPTH bytes can wait
    assign inReady  = ((q.count + CW'(q.outValid)) < CW'(DEPTH));
    assign outValid = q.outValid;
    assign outData  = q.outData;

    // Output stage refills whenever it is empty or being taken
    always_comb begin
        d = q;
        if (!q.outValid || outReady) begin
            if (q.count != '0) begin
                d.outData  = q.mem[q.rdPtr];
                d.outValid = 1'b1;
                d.rdPtr    = nextPtr(q.rdPtr);
                d.count    = d.count - CW'(1);
            end else begin
                d.outValid = 1'b0;
            end
        end
        if (inValid && inReady) begin
            d.mem[q.wrPtr] = inData;
            d.wrPtr        = nextPtr(q.wrPtr);
            d.count        = d.count + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

//--- irbf_master.sv
// Purpose: Behavioural bus master that frames reads and broadcast writes
// Assumes: SDA has a pull-up; the slave only pulls low
// Notes:   SCL stands high between frames; one bit takes 8 clk cycles
`timescale 1ns/1ps
module irbf_master (
    input  wire logic clk,
    output logic      scl,
    output logic      sdaDrv,
    input  wire logic sdaLine
);
    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    // Inputs move a fixed 2 ns after the edge so sampling never races
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // One bit; sampled mid-high so the slave's 1-clk answer delay is covered
    task automatic bitIo(input logic b, output logic s);
        sdaDrv = b;
        tick(2);
        scl = 1'b1;
        tick(2);
        s = sdaLine;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask

    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        sdaDrv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sdaDrv = 1'b0;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask

    // Stop: SDA rises while SCL is high
    task automatic stop();
        sdaDrv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        sdaDrv = 1'b1;
        tick(4);
    endtask

    // Byte to the slave, MSB first, then the slave's acknowledge
    task automatic byteOut(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(d[i], s);
        end
        bitIo(1'b1, s);
        ack = !s;
    endtask

    // Byte from the slave; master acks all but the last one
    task automatic byteIn(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, d[i]);
        end
        bitIo(!ackIt, s);
    endtask
endmodule

//--- irbf_pkg.sv
// Purpose: Shared constants and types for the serial-bus slave read and broadcast framing
// Assumes: SCL and SDA arrive already synchronous to clk (50 MHz)
// Notes:   Register map behind the select byte lives in the core, not here
// How it works
// - Read: select-byte write, repeated start, read address
// - Single read returns one byte, master then ends
// - Multi-byte read sends highest byte first
// - Broadcast address 0000xxx write is accepted, acknowledged
// - Own address is 1110 plus select pins
package irbf_pkg;
    localparam logic [3:0] IRBF_OWN_ADDR_HI   = 4'hE;   // Fixed upper address nibble
    localparam logic [3:0] IRBF_BCAST_ADDR_HI = 4'h0;   // Broadcast upper address nibble
    localparam logic [3:0] IRBF_REG_MAX       = 4'h8;   // Highest register the core decodes
    localparam int         IRBF_FIFO_DEPTH    = 8;      // Receive buffer depth in bytes
    localparam logic [2:0] IRBF_LAST_BIT      = 3'h7;   // Bit counter value of a byte's last bit

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA,
        ST_WDATA_ACK, ST_RD_LOAD, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
    } irbf_state_e;

    // One received data byte, tagged with its register and broadcast origin
    typedef struct packed {
        logic [7:0] regSel;
        logic [7:0] data;
        logic       bcast;
    } irbf_wr_s;

    // Complete state of the bus slave
    typedef struct packed {
        irbf_state_e state;
        logic        sclPrev;
        logic        sdaPrev;
        logic [7:0]  shift;
        logic [2:0]  bitCnt;
        logic        ackPhase;
        logic        rw;
        logic        bcast;
        logic [7:0]  regSel;
        logic [31:0] word;
        logic [1:0]  byteIdx;
        logic        exhausted;
        logic [7:0]  txShift;
        logic        sdaOut;
        logic        sdaOe_n;
        logic        readStrobe;
        logic        pushValid;
        irbf_wr_s    pushData;
    } irbf_slv_s;

    localparam irbf_slv_s IRBF_SLV_RST = '{state: ST_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1,
        shift: 8'h00, bitCnt: 3'h0, ackPhase: 1'b0, rw: 1'b0, bcast: 1'b0, regSel: 8'h00,
        word: 32'h0000_0000, byteIdx: 2'h0, exhausted: 1'b0, txShift: 8'h00, sdaOut: 1'b0,
        sdaOe_n: 1'b1, readStrobe: 1'b0, pushValid: 1'b0, pushData: '0};
endpackage

//--- irbf_slave.sv
// Purpose: Serial-bus slave framing for register reads and broadcast writes
// Assumes: scl and sdaIn are synchronous to clk; core answers readWord from registerSelectByte
// Notes:   Open-drain SDA; the pin is pulled low only while sdaOe_n is low
`timescale 1ns/1ps
module irbf_slave #(
    parameter int FIFO_DEPTH = irbf_pkg::IRBF_FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        scl,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe_n,
    input  wire logic        addressSelectPin2,
    input  wire logic        addressSelectPin1,
    input  wire logic        addressSelectPin0,
    output logic [7:0]       registerSelectByte,
    input  wire logic [31:0] readWord,
    input  wire logic [1:0]  readLen,
    output logic             readStrobe,
    output irbf_pkg::irbf_wr_s wrData,
    output logic             wrValid,
    input  wire logic        wrReady
);
    import irbf_pkg::*;

    irbf_slv_s  q;
    irbf_slv_s  d;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic [7:0] rxByte;
    logic       byteDone;
    logic       fifoInReady;

    // Byte of the read word at a given lane
    function automatic logic [7:0] byteOf(input logic [31:0] w, input logic [1:0] idx);
        return w[8*idx +: 8];
    endfunction

    // Put the first bit of the current read byte on the wire
    function automatic irbf_slv_s loadTx(input irbf_slv_s s);
        irbf_slv_s  r;
        logic [7:0] tx;
        r         = s;
        tx        = s.exhausted ? 8'h00 : byteOf(s.word, s.byteIdx);
        r.sdaOe_n = tx[7];
        r.txShift = {tx[6:0], 1'b0};
        r.bitCnt  = 3'h1;
        r.state   = ST_RDATA;
        return r;
    endfunction

    function automatic logic ownAddr(input logic [7:0] b, input logic [2:0] pins);
        return (b[7:4] == IRBF_OWN_ADDR_HI) && (b[3:1] == pins);
    endfunction

    function automatic logic bcastAddr(input logic [7:0] b);
        return (b[7:4] == IRBF_BCAST_ADDR_HI) && !b[0];
    endfunction

    // Bus conditions; SDA moves while SCL is high only for start and stop
    assign sclRise   = scl && !q.sclPrev;
    assign sclFall   = !scl && q.sclPrev;
    assign startCond = scl && q.sclPrev && q.sdaPrev && !sdaIn;
    assign stopCond  = scl && q.sclPrev && !q.sdaPrev && sdaIn;
    assign rxByte    = {q.shift[6:0], sdaIn};
    assign byteDone  = sclRise && (q.bitCnt == IRBF_LAST_BIT) && !startCond && !stopCond;

    // Framing state machine
    always_comb begin
        d            = q;
        d.sclPrev    = scl;
        d.sdaPrev    = sdaIn;
        d.readStrobe = 1'b0;
        d.pushValid  = 1'b0;
        if (startCond) begin
            d.state   = ST_ADDR;         // Also covers the repeated start of a read
            d.bitCnt  = 3'h0;
            d.sdaOe_n = 1'b1;
        end else if (stopCond) begin
            d.state   = ST_IDLE;
            d.sdaOe_n = 1'b1;
        end else begin
            unique case (q.state)
                ST_IDLE, ST_IGNORE: begin
                    d.sdaOe_n = 1'b1;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (sclRise) begin
                        d.shift  = rxByte;
                        d.bitCnt = q.bitCnt + 3'h1;
                    end
                    if (byteDone) begin
                        d.ackPhase = 1'b0;
                        if (q.state == ST_ADDR) begin
                            if (ownAddr(rxByte, {addressSelectPin2, addressSelectPin1,
                                                 addressSelectPin0})) begin
                                d.state = ST_ADDR_ACK;
                                d.rw    = rxByte[0];
                                d.bcast = 1'b0;
                                if (rxByte[0]) begin
                                    // Read word captured once so all bytes are coherent
                                    d.word       = readWord;
                                    d.byteIdx    = readLen;
                                    d.exhausted  = 1'b0;
                                    d.readStrobe = 1'b1;
                                end
                            end else if (bcastAddr(rxByte)) begin
                                d.state = ST_ADDR_ACK;
                                d.rw    = 1'b0;
                                d.bcast = 1'b1;
                            end else begin
                                d.state = ST_IGNORE;
                            end
                        end else if (q.state == ST_REG) begin
                            d.regSel = rxByte;           // Range is the core's concern
                            d.state  = ST_REG_ACK;
                        end else if (fifoInReady) begin
                            d.pushValid = 1'b1;
                            d.pushData  = '{regSel: q.regSel, data: rxByte, bcast: q.bcast};
                            d.state     = ST_WDATA_ACK;
                        end else begin
                            d.state = ST_IGNORE;  // Full buffer: no acknowledge, master retries
                        end
                    end
                end
                ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        if (!q.ackPhase) begin
                            d.sdaOe_n  = 1'b0;       // Pull low for acknowledge
                            d.ackPhase = 1'b1;
                        end else begin
                            d.sdaOe_n  = 1'b1;
                            d.ackPhase = 1'b0;
                            d.bitCnt   = 3'h0;
                            if (q.state == ST_ADDR_ACK && q.rw) begin
                                d = loadTx(d);       // First data byte follows at once
                            end else if (q.state == ST_ADDR_ACK) begin
                                d.state = ST_REG;
                            end else begin
                                d.state = ST_WDATA;  // Further bytes until stop
                            end
                        end
                    end
                end
                ST_RD_LOAD: begin
                    if (sclFall) begin
                        d = loadTx(d);
                    end
                end
                ST_RDATA: begin
                    if (sclFall) begin
                        if (q.bitCnt == 3'h0) begin
                            d.sdaOe_n = 1'b1;        // Free SDA for the master's answer
                            d.state   = ST_RDATA_ACK;
                        end else begin
                            d.sdaOe_n = q.txShift[7];
                            d.txShift = {q.txShift[6:0], 1'b0};
                            d.bitCnt  = q.bitCnt + 3'h1;
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclRise) begin
                        if (!sdaIn) begin
                            // Next lower byte; past the lowest the slave sends zeros
                            if (q.byteIdx == 2'h0) begin
                                d.exhausted = 1'b1;
                            end else begin
                                d.byteIdx = q.byteIdx - 2'h1;
                            end
                            d.state = ST_RD_LOAD;
                        end else begin
                            d.state = ST_IGNORE;     // Not-acknowledge ends the read
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= IRBF_SLV_RST;
        end else begin
            q <= d;
        end
    end

    // Received bytes wait here until the core takes them
    irbf_fifo #(
        .WIDTH ($bits(irbf_wr_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .inValid  (q.pushValid),
        .inData   (q.pushData),
        .inReady  (fifoInReady),
        .outValid (wrValid),
        .outData  (wrData),
        .outReady (wrReady)
    );

    assign sdaOut             = q.sdaOut;
    assign sdaOe_n            = q.sdaOe_n;
    assign registerSelectByte = q.regSel;
    assign readStrobe         = q.readStrobe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_addrDone;
        byteDone && q.state == ST_ADDR;
    endsequence

    sequence s_ackFirstFall;
        (q.state == ST_ADDR_ACK || q.state == ST_WDATA_ACK) && !q.ackPhase && sclFall
            && !startCond && !stopCond;
    endsequence

    property p_addr_match;
        s_addrDone and ownAddr(rxByte, {addressSelectPin2, addressSelectPin1,
                                        addressSelectPin0})
            |=> q.state == ST_ADDR_ACK && !q.bcast;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("own address not taken");

    property p_addr_reject;
        s_addrDone and !ownAddr(rxByte, {addressSelectPin2, addressSelectPin1,
                                         addressSelectPin0}) and !bcastAddr(rxByte)
            |=> q.state == ST_IGNORE;
    endproperty
    a_addr_reject: assert property (p_addr_reject) else $error("foreign address taken");

    property p_bcast;
        s_addrDone and bcastAddr(rxByte) and (rxByte[3:1] != {addressSelectPin2,
            addressSelectPin1, addressSelectPin0} || rxByte[7:4] != IRBF_OWN_ADDR_HI)
            |=> q.state == ST_ADDR_ACK && q.bcast;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast address not taken");

    property p_ack_drive;
        s_ackFirstFall |=> !q.sdaOe_n ##1 q.ackPhase;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

    property p_read_load;
        s_addrDone and ownAddr(rxByte, {addressSelectPin2, addressSelectPin1,
                                        addressSelectPin0}) and rxByte[0]
            |=> q.readStrobe && q.word == $past(readWord) && q.rw;
    endproperty
    a_read_load: assert property (p_read_load) else $error("read word not captured");

    property p_first_byte;
        q.state == ST_ADDR_ACK && q.ackPhase && q.rw && sclFall && !startCond && !stopCond
            |=> q.state == ST_RDATA && q.bitCnt == 3'h1
                && q.sdaOe_n == q.word[{q.byteIdx, 3'h7}];
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("read byte not started");

    property p_desc;
        q.state == ST_RDATA_ACK && sclRise && !sdaIn && q.byteIdx != 2'h0
            && !startCond && !stopCond
            |=> q.state == ST_RD_LOAD && q.byteIdx == $past(q.byteIdx) - 2'h1;
    endproperty
    a_desc: assert property (p_desc) else $error("read byte order wrong");

    property p_push;
        byteDone && q.state == ST_WDATA && fifoInReady
            |=> q.pushValid && q.pushData.data == $past(rxByte) && q.state == ST_WDATA_ACK;
    endproperty
    a_push: assert property (p_push) else $error("write byte not buffered");
endmodule

//--- test_irbf_slave.sv
// Purpose: Self-checking bench for the read and broadcast framing slave
// Assumes: Core side is modelled in the bench; master model drives the bus
// Notes:   FIFO refuses the first byte after its depth is filled
`timescale 1ns/1ps
module test_irbf_slave;
    import irbf_pkg::*;
    typedef struct packed {
        logic [2:0]  pins;
        logic [7:0]  sel;
        logic [1:0]  len;
        logic [31:0] word;
        logic        extra;
    } irbf_row_s;
    logic clk, srst, scl, sdaDrv, sdaLine, sdaOut, sdaOe_n, readStrobe, wrValid, wrReady;
    logic [2:0]  pins;
    logic [7:0]  registerSelectByte;
    logic [31:0] readWord;
    logic [1:0]  readLen;
    irbf_wr_s    wrData;
    irbf_wr_s    got[$];
    int          failures, compares, strobes;
    irbf_row_s   rows[4] = '{'{3'h0, 8'h00, 2'h0, 32'h0000_00A5, 1'b1},
        '{3'h3, 8'h05, 2'h1, 32'h0000_3C96, 1'b0}, '{3'h5, 8'h07, 2'h2, 32'h00E1_7B42, 1'b0},
        '{3'h7, 8'h08, 2'h3, 32'hF00D_6A19, 1'b1}};

    // Open-drain wire with pull-up
    assign sdaLine = sdaDrv & (sdaOe_n | sdaOut);

    irbf_slave u_irbf_slave (.clk(clk), .srst(srst), .scl(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addressSelectPin2(pins[2]),
        .addressSelectPin1(pins[1]), .addressSelectPin0(pins[0]),
        .registerSelectByte(registerSelectByte), .readWord(readWord), .readLen(readLen),
        .readStrobe(readStrobe), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady));
    irbf_master u_irbf_master (.clk(clk), .scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Core side: collect accepted bytes and count read strobes
    always @(posedge clk) begin
        if (wrValid === 1'b1 && wrReady === 1'b1) got.push_back(wrData);
        if (readStrobe === 1'b1) strobes++;
    end

    // Hang guard, well above the whole sequence
    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        summarize();
    end

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bounded wait for the core to have taken n bytes
    task automatic waitGot(input int n);
        for (int i = 0; i < 2000 && got.size() < n; i++) @(posedge clk);
        if (got.size() < n) begin
            failures++;
            $display("BAD drain expected %0d seen %0d", n, got.size());
            summarize();
        end
    endtask

    // Full read: select-byte write, repeated start, read address, lanes high to low
    task automatic doRead(input irbf_row_s r);
        logic a;
        logic [7:0] d;
        int s0;
        pins = r.pins;
        readWord = r.word;
        readLen = r.len;
        s0 = strobes;
        u_irbf_master.start();
        u_irbf_master.byteOut({IRBF_OWN_ADDR_HI, r.pins, 1'b0}, a);
        check("ack waddr", a, 1);
        u_irbf_master.byteOut(r.sel, a);
        check("ack sel", a, 1);
        u_irbf_master.start();
        u_irbf_master.byteOut({IRBF_OWN_ADDR_HI, r.pins, 1'b1}, a);
        check("ack raddr", a, 1);
        for (int k = 0; k <= r.len; k++) begin
            u_irbf_master.byteIn(k != r.len || r.extra, d);
            check("rdata", d, r.word[8*(r.len-k)+:8]);
        end
        if (r.extra) begin
            u_irbf_master.byteIn(1'b0, d);
            check("past last", d, 8'h00);
        end
        u_irbf_master.stop();
        check("select", registerSelectByte, r.sel);
        check("strobes", strobes - s0, 1);
        check("released", sdaOe_n, 1'b1);
    endtask

    initial begin
        logic a;
        int n;
        srst = 1'b1;
        pins = 3'h0;
        readWord = 32'h0;
        readLen = 2'h0;
        wrReady = 1'b0;
        failures = 0;
        compares = 0;
        strobes = 0;
        repeat (4) @(posedge clk);
        #2 srst = 1'b0;
        check("rst oe", sdaOe_n, 1'b1);
        check("rst out", sdaOut, 1'b0);
        check("rst wv", wrValid, 1'b0);
        check("rst sel", registerSelectByte, 8'h00);
        check("rst rs", readStrobe, 1'b0);
        $display("test reset done");
        foreach (rows[i]) doRead(rows[i]);
        $display("test reads done");
        // Foreign address, and broadcast pattern with read set, are refused
        pins = 3'h2;
        foreach (rows[i]) begin
            if (i < 2) begin
                u_irbf_master.start();
                u_irbf_master.byteOut(i == 0 ? {4'hE, 3'h5, 1'b0} : {4'h0, 3'h2, 1'b1}, a);
                check("nack addr", a, 0);
                u_irbf_master.stop();
            end
        end
        $display("test refuse done");
        // Broadcast write: each byte acked, tagged, in sent order
        got.delete();
        u_irbf_master.start();
        u_irbf_master.byteOut({IRBF_BCAST_ADDR_HI, 3'h5, 1'b0}, a);
        check("ack bcast", a, 1);
        u_irbf_master.byteOut(8'h03, a);
        check("ack bsel", a, 1);
        u_irbf_master.byteOut(8'hC3, a);
        check("ack b0", a, 1);
        u_irbf_master.byteOut(8'h5A, a);
        check("ack b1", a, 1);
        u_irbf_master.stop();
        wrReady = 1'b1;
        waitGot(2);
        check("b0", got[0], {8'h03, 8'hC3, 1'b1});
        check("b1", got[1], {8'h03, 8'h5A, 1'b1});
        $display("test broadcast done");
        // Own write with a stalled core until the buffer refuses
        got.delete();
        wrReady = 1'b0;
        u_irbf_master.start();
        u_irbf_master.byteOut({IRBF_OWN_ADDR_HI, 3'h2, 1'b0}, a);
        u_irbf_master.byteOut(8'h01, a);
        n = 0;
        while (a === 1'b1 && n < 14) begin
            u_irbf_master.byteOut(8'h10 + 8'(n), a);
            if (a === 1'b1) n++;
        end
        check("full nack", a, 0);
        check("fill", n, IRBF_FIFO_DEPTH);
        u_irbf_master.stop();
        wrReady = 1'b1;
        waitGot(n);
        foreach (got[i]) check("fifo", got[i], {8'h01, 8'h10 + 8'(i), 1'b0});
        check("empty", got.size(), n);
        $display("test fifo done");
        // Mid-run reset drops a stalled byte, then a read must still work
        got.delete();
        wrReady = 1'b0;
        u_irbf_master.start();
        u_irbf_master.byteOut({IRBF_BCAST_ADDR_HI, 3'h1, 1'b0}, a);
        u_irbf_master.byteOut(8'h02, a);
        u_irbf_master.byteOut(8'h77, a);
        u_irbf_master.stop();
        check("pre wv", wrValid, 1'b1);
        check("pre sel", registerSelectByte, 8'h02);
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #2 srst = 1'b0;
        check("mid wv", wrValid, 1'b0);
        check("mid sel", registerSelectByte, 8'h00);
        check("mid oe", sdaOe_n, 1'b1);
        wrReady = 1'b1;
        doRead(rows[2]);
        check("mid flush", got.size(), 0);
        $display("test midrun reset done");
        summarize();
    end
endmodule
